// ### common/ppd_pkg.sv
`default_nettype none
package ppd_pkg;

   // Register byte addresses on the bus, one aligned word each.
   localparam logic [11:0] ADR_S_DATA   = 12'h248;
   localparam logic [11:0] ADR_S_DIR    = 12'h24C;
   localparam logic [11:0] ADR_J_LEVEL  = 12'h250;
   localparam logic [11:0] ADR_J_DATA   = 12'h254;
   localparam logic [11:0] ADR_J_DIR    = 12'h258;
   localparam logic [11:0] ADR_P_DATA   = 12'h25C;
   localparam logic [11:0] ADR_P_DIR    = 12'h260;
   localparam logic [11:0] ADR_P_PE     = 12'h264;
   localparam logic [11:0] ADR_P_POL    = 12'h268;
   localparam logic [11:0] ADR_P_LEVEL  = 12'h26C;
   localparam logic [11:0] ADR_AD_DATA  = 12'h270;
   localparam logic [11:0] ADR_AD_DIR   = 12'h274;
   localparam logic [11:0] ADR_AD_DIEN  = 12'h278;
   localparam logic [11:0] ADR_AD_LEVEL = 12'h27C;

   // Implemented pins of each port.
   localparam logic [7:0] MASK_S  = 8'h0F;
   localparam logic [7:0] MASK_J  = 8'hC7;
   localparam logic [7:0] MASK_P  = 8'hBF;
   localparam logic [7:0] MASK_AD = 8'hFF;

   localparam logic [7:0]  REG_RESET  = 8'h00;
   localparam logic [23:0] DAT_UPPER  = 24'h000000;
   localparam int          SCI_TXD_BIT = 1;
   localparam int          SCI_RXD_BIT = 0;

   typedef enum logic [3:0] {
      REG_S_DATA   = 4'h0,
      REG_S_DIR    = 4'h1,
      REG_J_LEVEL  = 4'h2,
      REG_J_DATA   = 4'h3,
      REG_J_DIR    = 4'h4,
      REG_P_DATA   = 4'h5,
      REG_P_DIR    = 4'h6,
      REG_P_PE     = 4'h7,
      REG_P_POL    = 4'h8,
      REG_P_LEVEL  = 4'h9,
      REG_AD_DATA  = 4'hA,
      REG_AD_DIR   = 4'hB,
      REG_AD_DIEN  = 4'hC,
      REG_AD_LEVEL = 4'hD,
      REG_NONE     = 4'hF
   } ppd_reg_t;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } ppd_bus_st_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } ppd_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } ppd_wb_rsp_t;

   typedef struct packed {
      logic [7:0] s;
      logic [7:0] j;
      logic [7:0] p;
      logic [7:0] ad;
   } ppd_pins_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } ppd_port_drive_t;

   typedef struct packed {
      ppd_port_drive_t s;
      ppd_port_drive_t j;
      ppd_port_drive_t p;
      ppd_port_drive_t ad;
   } ppd_drive_t;

   typedef struct packed {
      ppd_bus_st_t bus_st;
      logic        ack;
      logic [7:0]  rdat;
      logic [7:0]  s_data;
      logic [7:0]  s_dir;
      logic [7:0]  j_data;
      logic [7:0]  j_dir;
      logic [7:0]  p_data;
      logic [7:0]  p_dir;
      logic [7:0]  p_pe;
      logic [7:0]  p_pol;
      logic [7:0]  ad_data;
      logic [7:0]  ad_dir;
      logic [7:0]  ad_dien;
      ppd_drive_t  drv;
      logic        rxd;
      logic [7:0]  pull_up;
      logic [7:0]  pull_dn;
      logic [7:0]  p_prev;
      logic [7:0]  p_edge;
   } ppd_state_t;

   typedef struct packed {
      ppd_pins_t smp;
   } ppd_smp_state_t;

endpackage
`default_nettype wire

// ### logic/ppd_pin_sample.sv
`default_nettype none
// Every pin is taken through one register so that reads see a steady level.
module ppd_pin_sample (
   // Clock, reset and clock enable.
   input  wire logic          sys_clk,
   input  wire logic          reset,
   input  wire logic          ce,
   // Pins and their registered levels.
   input  wire ppd_pkg::ppd_pins_t pin_i,
   output var  ppd_pkg::ppd_pins_t smp_o
);
   ppd_pkg::ppd_smp_state_t q;
   ppd_pkg::ppd_smp_state_t d;

   always_comb begin
      d     = q;
      d.smp = pin_i;
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign smp_o = q.smp;
endmodule // ppd_pin_sample
`default_nettype wire

// ### logic/ppd_port_top.sv
// Operation
// - Port S output pin drives the stored data bit.
// - Port S read gives data bit if direction is 1, else sampled pin.
// - Enabled serial unit owns bit 1 as transmit and bit 0 as receive.
// - Port S data register is readable and writable at any time.
// - Port J level read always returns sampled pins 7-6 and 2-0.
// - Writes to the port J level register change nothing.
// - Port J direction bit set makes the pin an output, clear an input.
// - Port AD direction per pin; digital input works only when enabled.
// - Port P pull enable bit turns the pull device on or off.
// - Port P pull enable has no effect on an output pin.
// - Polarity 1 means pull-down and rising edge, 0 pull-up and falling.
// - Pull direction of an enabled input comes from the polarity bit.
`default_nettype none
module ppd_port_top (
   // Clock, reset and clock enable.
   input  wire logic                 sys_clk,
   input  wire logic                 reset,
   input  wire logic                 ce,
   // Register bus.
   input  wire ppd_pkg::ppd_wb_req_t wb_req_i,
   output var  ppd_pkg::ppd_wb_rsp_t wb_rsp_o,
   // Pins.
   input  wire ppd_pkg::ppd_pins_t   pin_i,
   output var  ppd_pkg::ppd_drive_t  pin_drive_o,
   // Serial alternate function.
   input  wire logic                 sci_en_i,
   input  wire logic                 sci_txd_i,
   output logic                      sci_rxd_o,
   // Pull devices, converter input gates and edge events.
   output logic [7:0]                p_pull_up_o,
   output logic [7:0]                p_pull_down_o,
   output logic [7:0]                ad_din_en_o,
   output logic [7:0]                p_edge_o
);
   ppd_pkg::ppd_state_t q;
   ppd_pkg::ppd_state_t d;
   ppd_pkg::ppd_pins_t  smp;
   ppd_pkg::ppd_reg_t   reg_sel;
   logic [7:0]          rd_val;
   logic [7:0]          wdat;
   logic [7:0]          s_expect;
   logic                bus_req;
   logic                bus_wr;

   function automatic ppd_pkg::ppd_reg_t ppd_decode(input logic [11:0] adr);
      logic [9:0] w;
      w = adr[11:2];
      if (w == ppd_pkg::ADR_S_DATA[11:2]) begin
         return ppd_pkg::REG_S_DATA;
      end else if (w == ppd_pkg::ADR_S_DIR[11:2]) begin
         return ppd_pkg::REG_S_DIR;
      end else if (w == ppd_pkg::ADR_J_LEVEL[11:2]) begin
         return ppd_pkg::REG_J_LEVEL;
      end else if (w == ppd_pkg::ADR_J_DATA[11:2]) begin
         return ppd_pkg::REG_J_DATA;
      end else if (w == ppd_pkg::ADR_J_DIR[11:2]) begin
         return ppd_pkg::REG_J_DIR;
      end else if (w == ppd_pkg::ADR_P_DATA[11:2]) begin
         return ppd_pkg::REG_P_DATA;
      end else if (w == ppd_pkg::ADR_P_DIR[11:2]) begin
         return ppd_pkg::REG_P_DIR;
      end else if (w == ppd_pkg::ADR_P_PE[11:2]) begin
         return ppd_pkg::REG_P_PE;
      end else if (w == ppd_pkg::ADR_P_POL[11:2]) begin
         return ppd_pkg::REG_P_POL;
      end else if (w == ppd_pkg::ADR_P_LEVEL[11:2]) begin
         return ppd_pkg::REG_P_LEVEL;
      end else if (w == ppd_pkg::ADR_AD_DATA[11:2]) begin
         return ppd_pkg::REG_AD_DATA;
      end else if (w == ppd_pkg::ADR_AD_DIR[11:2]) begin
         return ppd_pkg::REG_AD_DIR;
      end else if (w == ppd_pkg::ADR_AD_DIEN[11:2]) begin
         return ppd_pkg::REG_AD_DIEN;
      end else if (w == ppd_pkg::ADR_AD_LEVEL[11:2]) begin
         return ppd_pkg::REG_AD_LEVEL;
      end else begin
         return ppd_pkg::REG_NONE;
      end
   endfunction

   ppd_pin_sample u_sample (
      .sys_clk (sys_clk),
      .reset   (reset),
      .ce      (ce),
      .pin_i   (pin_i),
      .smp_o   (smp)
   );

   assign reg_sel = ppd_decode(wb_req_i.adr);
   assign bus_req = wb_req_i.cyc && wb_req_i.stb && (q.bus_st == ppd_pkg::BUS_IDLE);
   assign bus_wr  = bus_req && wb_req_i.we && wb_req_i.sel[0];
   assign wdat    = wb_req_i.dat[7:0];
   assign s_expect = ((q.s_data & q.s_dir) | (smp.s & ~q.s_dir)) & ppd_pkg::MASK_S;

   // Read multiplexer; level registers show the sampled pins, not the stored data.
   always_comb begin
      case (reg_sel)
         ppd_pkg::REG_S_DATA:   rd_val = s_expect;
         ppd_pkg::REG_S_DIR:    rd_val = q.s_dir;
         ppd_pkg::REG_J_LEVEL:  rd_val = smp.j & ppd_pkg::MASK_J;
         ppd_pkg::REG_J_DATA:   rd_val = q.j_data;
         ppd_pkg::REG_J_DIR:    rd_val = q.j_dir;
         ppd_pkg::REG_P_DATA:   rd_val = q.p_data;
         ppd_pkg::REG_P_DIR:    rd_val = q.p_dir;
         ppd_pkg::REG_P_PE:     rd_val = q.p_pe;
         ppd_pkg::REG_P_POL:    rd_val = q.p_pol;
         ppd_pkg::REG_P_LEVEL:  rd_val = smp.p & ppd_pkg::MASK_P;
         ppd_pkg::REG_AD_DATA:  rd_val = q.ad_data;
         ppd_pkg::REG_AD_DIR:   rd_val = q.ad_dir;
         ppd_pkg::REG_AD_DIEN:  rd_val = q.ad_dien;
         ppd_pkg::REG_AD_LEVEL: rd_val = smp.ad & q.ad_dien;
         default:               rd_val = ppd_pkg::REG_RESET;
      endcase
   end

   always_comb begin
      d = q;
      case (q.bus_st)
         ppd_pkg::BUS_IDLE: begin
            if (bus_req) begin
               d.bus_st = ppd_pkg::BUS_ACK;
               d.ack    = 1'b1;
               d.rdat   = rd_val;
            end
         end
         ppd_pkg::BUS_ACK: begin
            // The master releases the request after the ack, so one idle cycle follows.
            d.bus_st = ppd_pkg::BUS_IDLE;
            d.ack    = 1'b0;
         end
         default: begin
            d.bus_st = ppd_pkg::BUS_IDLE;
            d.ack    = 1'b0;
         end
      endcase

      // Level registers have no write case, so a write to them leaves all port registers alone.
      if (bus_wr) begin
         case (reg_sel)
            ppd_pkg::REG_S_DATA:  d.s_data  = wdat & ppd_pkg::MASK_S;
            ppd_pkg::REG_S_DIR:   d.s_dir   = wdat & ppd_pkg::MASK_S;
            ppd_pkg::REG_J_DATA:  d.j_data  = wdat & ppd_pkg::MASK_J;
            ppd_pkg::REG_J_DIR:   d.j_dir   = wdat & ppd_pkg::MASK_J;
            ppd_pkg::REG_P_DATA:  d.p_data  = wdat & ppd_pkg::MASK_P;
            ppd_pkg::REG_P_DIR:   d.p_dir   = wdat & ppd_pkg::MASK_P;
            ppd_pkg::REG_P_PE:    d.p_pe    = wdat & ppd_pkg::MASK_P;
            ppd_pkg::REG_P_POL:   d.p_pol   = wdat & ppd_pkg::MASK_P;
            ppd_pkg::REG_AD_DATA: d.ad_data = wdat & ppd_pkg::MASK_AD;
            ppd_pkg::REG_AD_DIR:  d.ad_dir  = wdat & ppd_pkg::MASK_AD;
            ppd_pkg::REG_AD_DIEN: d.ad_dien = wdat & ppd_pkg::MASK_AD;
            default: begin
            end
         endcase
      end

      d.drv.s.out = q.s_data;
      d.drv.s.oe  = q.s_dir & ppd_pkg::MASK_S;
      if (sci_en_i) begin
         d.drv.s.out[ppd_pkg::SCI_TXD_BIT] = sci_txd_i;
         d.drv.s.oe[ppd_pkg::SCI_TXD_BIT]  = 1'b1;
         d.drv.s.oe[ppd_pkg::SCI_RXD_BIT]  = 1'b0;
      end
      d.rxd = smp.s[ppd_pkg::SCI_RXD_BIT];

      d.drv.j.out = q.j_data;
      d.drv.j.oe  = q.j_dir & ppd_pkg::MASK_J;
      d.drv.p.out = q.p_data;
      d.drv.p.oe  = q.p_dir & ppd_pkg::MASK_P;
      d.drv.ad.out = q.ad_data;
      d.drv.ad.oe  = q.ad_dir;
      d.ad_dien    = d.ad_dien & ppd_pkg::MASK_AD;

      d.pull_up = q.p_pe & ~q.p_dir & ~q.p_pol & ppd_pkg::MASK_P;
      d.pull_dn = q.p_pe & ~q.p_dir & q.p_pol & ppd_pkg::MASK_P;

      d.p_prev = smp.p;
      d.p_edge = ppd_pkg::MASK_P & ((q.p_pol & smp.p & ~q.p_prev) | (~q.p_pol & ~smp.p & q.p_prev));
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign wb_rsp_o.ack  = q.ack;
   assign wb_rsp_o.dat  = {ppd_pkg::DAT_UPPER, q.rdat};
   assign pin_drive_o   = q.drv;
   assign sci_rxd_o     = q.rxd;
   assign p_pull_up_o   = q.pull_up;
   assign p_pull_down_o = q.pull_dn;
   assign ad_din_en_o   = q.ad_dien;
   assign p_edge_o      = q.p_edge;

   a_s_out_drive: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && !sci_en_i && q.s_dir[2]) |=> (pin_drive_o.s.oe[2] && pin_drive_o.s.out[2] == $past(q.s_data[2])))
      else $error("Port S output pin does not carry the stored bit.");

   a_s_read_src: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && bus_req && !wb_req_i.we && reg_sel == ppd_pkg::REG_S_DATA)
      |=> (wb_rsp_o.ack && wb_rsp_o.dat[3:0] == $past(s_expect[3:0])))
      else $error("Port S read returned the wrong source.");

   a_sci_pin_owner: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && sci_en_i) |=> (pin_drive_o.s.oe[1] && !pin_drive_o.s.oe[0] && pin_drive_o.s.out[1] == $past(sci_txd_i)))
      else $error("Serial unit does not own its pins.");

   a_s_write_any: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && bus_wr && reg_sel == ppd_pkg::REG_S_DATA) |=> (q.s_data == ($past(wdat) & ppd_pkg::MASK_S)))
      else $error("Port S write was not stored.");

   a_j_level_read: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && bus_req && !wb_req_i.we && reg_sel == ppd_pkg::REG_J_LEVEL)
      |=> (wb_rsp_o.dat[7:0] == ($past(smp.j) & ppd_pkg::MASK_J)))
      else $error("Port J level read does not show the pins.");

   a_j_level_nowr: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && bus_wr && reg_sel == ppd_pkg::REG_J_LEVEL)
      |=> ($stable(q.j_data) && $stable(q.j_dir) && $stable(q.p_pe) && $stable(q.s_data) && $stable(q.ad_dir)))
      else $error("Write to port J level changed state.");

   a_j_dir_oe: assert property (
      @(posedge sys_clk) disable iff (reset)
      ce |=> (pin_drive_o.j.oe == ($past(q.j_dir) & ppd_pkg::MASK_J)))
      else $error("Port J enables differ from direction.");

   a_ad_din_gate: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && bus_req && !wb_req_i.we && reg_sel == ppd_pkg::REG_AD_LEVEL)
      |=> ((wb_rsp_o.dat[7:0] & ~$past(q.ad_dien)) == ppd_pkg::REG_RESET))
      else $error("Port AD digital input seen while disabled.");

   a_p_pull_out: assert property (
      @(posedge sys_clk) disable iff (reset)
      ce |=> (((p_pull_up_o | p_pull_down_o) & pin_drive_o.p.oe) == ppd_pkg::REG_RESET))
      else $error("Pull device active on an output pin.");

   a_p_pull_enable: assert property (
      @(posedge sys_clk) disable iff (reset)
      ce |=> ((p_pull_up_o | p_pull_down_o) == ($past(q.p_pe) & ~$past(q.p_dir) & ppd_pkg::MASK_P)))
      else $error("Port P pull devices do not follow the enable bits.");

   // edge follows polarity.
   // The previous level is taken from the sampled pins two cycles back, not from the edge register.
   a_p_edge_pol: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && $past(ce)) |=> ((p_edge_o & ~(($past(q.p_pol) & $past(smp.p) & ~$past(smp.p, 2))
         | (~$past(q.p_pol) & ~$past(smp.p) & $past(smp.p, 2)))) == ppd_pkg::REG_RESET))
      else $error("Port P edge event does not match the selected polarity.");

   a_ad_dir_oe: assert property (
      @(posedge sys_clk) disable iff (reset)
      ce |=> (pin_drive_o.ad.oe == $past(q.ad_dir)))
      else $error("Port AD output enables differ from direction.");

   a_p_pull_dir: assert property (
      @(posedge sys_clk) disable iff (reset)
      ce |=> (p_pull_down_o == ($past(q.p_pe) & ~$past(q.p_dir) & $past(q.p_pol) & ppd_pkg::MASK_P)))
      else $error("Pull-down enables do not follow polarity.");

   a_s_upper_zero: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ce && bus_req && reg_sel == ppd_pkg::REG_S_DATA) |=> (wb_rsp_o.dat[7:4] == 4'h0 && q.s_data[7:4] == 4'h0))
      else $error("Port S upper bits are not zero.");

endmodule // ppd_port_top
`default_nettype wire

// ### sim/ppd_pin_model.sv
`default_nettype none
// Pad model: an external driver overrides the block's own drive, so that overload shows on the pins.
// A pin nobody holds shows the inverse of its last level rather than a friendly constant.
module ppd_pin_model (
   // Clock.
   input  wire logic                sys_clk,
   // Drive and pull controls from the block.
   input  wire ppd_pkg::ppd_drive_t drv,
   input  wire logic [7:0]          pull_up,
   input  wire logic [7:0]          pull_dn,
   // External drivers.
   input  wire ppd_pkg::ppd_pins_t  ext_val,
   input  wire ppd_pkg::ppd_pins_t  ext_en,
   // Resolved pin levels.
   output var  ppd_pkg::ppd_pins_t  pins
);
   ppd_pkg::ppd_pins_t last_q = '0;

   function automatic logic [7:0] res(input logic [7:0] o, oe, v, e, pu, pd, last);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         r[i] = e[i] ? v[i] : oe[i] ? o[i] : pu[i] ? 1'b1 : pd[i] ? 1'b0 : ~last[i];
      end
      return r;
   endfunction

   always_comb begin
      pins.s  = res(drv.s.out, drv.s.oe, ext_val.s, ext_en.s, 8'h00, 8'h00, last_q.s);
      pins.j  = res(drv.j.out, drv.j.oe, ext_val.j, ext_en.j, 8'h00, 8'h00, last_q.j);
      pins.p  = res(drv.p.out, drv.p.oe, ext_val.p, ext_en.p, pull_up, pull_dn, last_q.p);
      pins.ad = res(drv.ad.out, drv.ad.oe, ext_val.ad, ext_en.ad, 8'h00, 8'h00, last_q.ad);
   end

   always_ff @(posedge sys_clk) begin
      last_q <= pins;
   end
endmodule // ppd_pin_model
`default_nettype wire

// ### sim/port_pins_pull_direction_bench.sv
`default_nettype none
module port_pins_pull_direction_bench;
   timeunit 1ns;
   timeprecision 1ns;

   logic                 sys_clk = 1'b0;
   logic                 reset   = 1'b1;
   logic                 ce      = 1'b1;
   ppd_pkg::ppd_wb_req_t wb_req  = '0;
   ppd_pkg::ppd_wb_rsp_t wb_rsp;
   ppd_pkg::ppd_pins_t   pins;
   ppd_pkg::ppd_pins_t   ext_val = '{s: 8'h00, j: 8'hC5, p: 8'h00, ad: 8'hF0};
   ppd_pkg::ppd_pins_t   ext_en  = '{s: 8'hFF, j: 8'hFF, p: 8'hFE, ad: 8'hF0};
   ppd_pkg::ppd_drive_t  drv;
   logic                 sci_en  = 1'b0;
   logic                 sci_txd = 1'b1;
   logic                 sci_rxd;
   logic [7:0]           pull_up;
   logic [7:0]           pull_dn;
   logic [7:0]           din_en;
   logic [7:0]           p_edge;
   int                   err_count = 0;
   int                   n_tests   = 0;

   initial begin
      forever #25 sys_clk = ~sys_clk;
   end

   ppd_port_top dut (.sys_clk(sys_clk), .reset(reset), .ce(ce), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
      .pin_i(pins), .pin_drive_o(drv), .sci_en_i(sci_en), .sci_txd_i(sci_txd), .sci_rxd_o(sci_rxd),
      .p_pull_up_o(pull_up), .p_pull_down_o(pull_dn), .ad_din_en_o(din_en), .p_edge_o(p_edge));

   ppd_pin_model pads (.sys_clk(sys_clk), .drv(drv), .pull_up(pull_up), .pull_dn(pull_dn),
      .ext_val(ext_val), .ext_en(ext_en), .pins(pins));

   task automatic stop_test;
      if (err_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // Wide enough for the whole drive bundle of all four ports.
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Classic single cycle; the slave's latency is not assumed, only bounded.
   task automatic wb(input logic we, input logic [11:0] adr, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge sys_clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: adr, dat: {24'h000000, d}};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      if (wb_rsp.ack !== 1'b1) begin
         err_count++;
         stop_test();
      end
      q = wb_rsp.dat;
      wb_req <= '0;
   endtask

   task automatic wr(input logic [11:0] adr, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, adr, d, q);
   endtask

   task automatic rd(input logic [11:0] adr, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, adr, 8'h00, q);
      chk(q, exp);
   endtask

   task automatic settle;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic wait_edge(input logic [7:0] exp);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (p_edge === 8'h00 && n < 6);
      chk(p_edge, exp);
   endtask

   task automatic t_reset;
      chk(drv, 64'h0);
      chk({pull_up, pull_dn, sci_rxd}, 17'h0);
      rd(ppd_pkg::ADR_S_DATA, 32'h0);
      rd(ppd_pkg::ADR_P_PE, 32'h0);
      rd(12'h300, 32'h0);
   endtask

   task automatic t_port_s;
      wr(ppd_pkg::ADR_S_DATA, 8'hFF);
      wr(ppd_pkg::ADR_S_DIR, 8'hFF);
      rd(ppd_pkg::ADR_S_DATA, 32'h0F);
      settle();
      chk(drv.s, 16'h0F0F);
      ext_val.s <= 8'hA5;
      wr(ppd_pkg::ADR_S_DIR, 8'h0C);
      settle();
      rd(ppd_pkg::ADR_S_DATA, 32'h0D);
   endtask

   task automatic t_serial;
      wr(ppd_pkg::ADR_S_DIR, 8'h0F);
      sci_en  <= 1'b1;
      sci_txd <= 1'b0;
      settle();
      chk({drv.s.out[1], drv.s.oe[1:0], sci_rxd}, 4'b0101);
      sci_txd <= 1'b1;
      settle();
      chk(drv.s.out[1], 1'b1);
      sci_en <= 1'b0;
      settle();
      chk(drv.s.oe[1:0], 2'b11);
   endtask

   task automatic t_port_j;
      wr(ppd_pkg::ADR_J_DIR, 8'hFF);
      rd(ppd_pkg::ADR_J_DIR, 32'hC7);
      settle();
      chk(drv.j.oe, 8'hC7);
      rd(ppd_pkg::ADR_J_LEVEL, 32'hC5);
      wr(ppd_pkg::ADR_J_LEVEL, 8'h00);
      rd(ppd_pkg::ADR_J_LEVEL, 32'hC5);
      rd(ppd_pkg::ADR_J_DIR, 32'hC7);
   endtask

   task automatic t_port_ad;
      wr(ppd_pkg::ADR_AD_DIR, 8'h0F);
      wr(ppd_pkg::ADR_AD_DIEN, 8'h3C);
      settle();
      chk({din_en, drv.ad.oe}, 16'h3C0F);
      rd(ppd_pkg::ADR_AD_LEVEL, 32'h30);
   endtask

   task automatic t_port_p;
      logic [7:0] seen;
      wr(ppd_pkg::ADR_P_PE, 8'hFF);
      wr(ppd_pkg::ADR_P_POL, 8'h0F);
      wr(ppd_pkg::ADR_P_DIR, 8'h01);
      settle();
      chk(pull_up, 8'hB0);
      chk(pull_dn, 8'h0E);
      ext_val.p <= 8'h04;
      wait_edge(8'h04);
      ext_val.p <= 8'h80;
      seen = 8'h00;
      repeat (5) begin
         @(posedge sys_clk);
         seen = seen | p_edge;
      end
      chk(seen, 8'h00);
      ext_val.p <= 8'h00;
      wait_edge(8'h80);
   endtask

   // A request held while the clock enable is low must wait, then land once it rises.
   task automatic t_freeze;
      int n;
      @(posedge sys_clk);
      ce     <= 1'b0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: 1'b1, sel: 4'hF, adr: ppd_pkg::ADR_S_DATA, dat: 32'h0000000A};
      repeat (4) @(posedge sys_clk);
      chk({wb_rsp.ack, drv.s.out}, 9'h00F);
      ce <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      if (wb_rsp.ack !== 1'b1) begin
         err_count++;
         stop_test();
      end
      wb_req <= '0;
      settle();
      chk(drv.s.out, 8'h0A);
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_port_s();
      t_serial();
      t_port_j();
      t_port_ad();
      t_port_p();
      t_freeze();
      stop_test();
   end
endmodule // port_pins_pull_direction_bench
`default_nettype wire
